// ==== inc/slip_evt_defs.svh ====
/*
 * Constants of the slip-buffer event block: register indices, field
 * positions, reset values and buffer geometry.
 * Assumes it is included by its bare name, once or more.
 */
`ifndef SLIP_EVT_DEFS_SVH
`define SLIP_EVT_DEFS_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_STATUS 12'hb08
`define IDX_ENABLE 12'hb09
`define IDX_TX_STATUS 12'hb0a
`define APB_AW 16

// ==========================================================
// Field positions
`define BIT_RX_SLIP 0
`define BIT_RX_EMPTY 1
`define BIT_RX_FULL 2
`define BIT_TX_SLIP 5
`define BIT_TX_EMPTY 6
`define BIT_TX_FULL 7
`define ENABLE_MASK 8'he7

// ==========================================================
// Reset values
`define RST_STATUS 1'b0
`define RST_ENABLE 8'h00

// ==========================================================
// Buffer geometry: two E1 frames of 32 timeslots
`define SB_PTR_W 6
`define SB_CNT_W 7
`define SB_DEPTH 7'h40
`define SB_FRAME_PTR 6'h20
`define SB_FRAME_CNT 7'h20

`endif

// ==== inc/slip_evt_pkg.sv ====
/*
 * Types shared by the slip-buffer event block.
 * Assumes slip_evt_defs.svh is on the include path.
 */
package slip_evt_pkg;
`include "slip_evt_defs.svh"

    typedef logic [`SB_PTR_W-1:0] ptr_t;
    typedef logic [`SB_CNT_W-1:0] cnt_t;
    typedef logic [7:0] byte_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_ACCESS = 1'b1
    } apb_state_e;
endpackage

// ==== inc/slip_event_if.sv ====
/*
 * Slip events from one slip buffer to the register block.
 * Assumes both ends sit on the same core clock.
 */
`timescale 1ns/1ps
interface slip_event_if;
    logic full_slip;
    logic empty_slip;

    modport src (output full_slip, output empty_slip);
    modport dst (input full_slip, input empty_slip);
endinterface

// ==== rtl/slip_buffer.sv ====
/*
 * Two-frame slip buffer: deletes a frame on a write when full,
 * repeats a frame on a read when empty, and reports each slip.
 * Assumes writer and reader run on the core clock.
 */
`timescale 1ns/1ps
`include "slip_evt_defs.svh"
module slip_buffer
    import slip_evt_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Stream
    input wire logic i_wr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_rd,
    output byte_t o_rd_data,
    output logic o_rd_valid,
    // Events
    slip_event_if.src ev
);
    byte_t mem [0:`SB_DEPTH-1];
    ptr_t wr_ptr;
    ptr_t rd_ptr;
    cnt_t count;

    wire is_full = (count == `SB_DEPTH);
    wire full_slip = i_wr & is_full & ~i_rd;
    wire empty_slip = i_rd & (count == '0);
    // Step back one frame so the last frame is read again
    wire ptr_t rd_base = empty_slip ? ptr_t'(rd_ptr - `SB_FRAME_PTR) : rd_ptr;
    // Dropping the oldest frame makes room for the new word
    wire ptr_t next_rd_ptr = full_slip ? ptr_t'(rd_ptr + `SB_FRAME_PTR) :
                             (i_rd ? ptr_t'(rd_base + 1'b1) : rd_ptr);
    wire cnt_t next_count = cnt_t'(count + (empty_slip ? `SB_FRAME_CNT : '0)
                            - (full_slip ? `SB_FRAME_CNT : '0)
                            + {6'h00, i_wr} - {6'h00, i_rd});

    always_ff @(posedge i_core_clk) begin
        if (i_wr) begin
            mem[wr_ptr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            o_rd_valid <= 1'b0;
            o_rd_data <= 8'h00;
            ev.full_slip <= 1'b0;
            ev.empty_slip <= 1'b0;
        end else begin
            wr_ptr <= i_wr ? ptr_t'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
            o_rd_valid <= i_rd;
            o_rd_data <= i_rd ? mem[rd_base] : o_rd_data;
            ev.full_slip <= full_slip;
            ev.empty_slip <= empty_slip;
        end
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    AST_REPEAT_FRAME: assert property (
        (i_rd && count == 0 && !i_wr) |=> (count == 31))
        else $error("empty read did not restore one frame");
    AST_DELETE_FRAME: assert property (
        (i_wr && count == 64 && !i_rd) |=> (count == 33))
        else $error("full write did not delete one frame");
endmodule

// ==== rtl/event_latch.sv ====
/*
 * Sticky event flags: a set pulse latches a bit, a clear mask drops it,
 * and a set in the same cycle as its clear wins.
 * Assumes set and clear come from the core clock domain.
 */
`timescale 1ns/1ps
`include "slip_evt_defs.svh"
module event_latch
    import slip_evt_pkg::*;
#(
    parameter int W = 6
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Set and clear
    input wire logic [W-1:0] i_set,
    input wire logic [W-1:0] i_clr,
    output logic [W-1:0] o_flags
);
    wire [W-1:0] next_flags;

    genvar k;
    generate
        for (k = 0; k < W; k++) begin : g_flag
            // A set in the clearing cycle wins, so no event is lost
            assign next_flags[k] = i_set[k] | (o_flags[k] & ~i_clr[k]);
        end
    endgenerate

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_flags <= {W{`RST_STATUS}};
        end else begin
            o_flags <= next_flags;
        end
    end
endmodule

// ==== rtl/slip_event_ctrl.sv ====
/*
 * One E1 channel's receive and transmit slip buffers with their slip
 * event status, enable register and interrupt, reached over APB.
 * Assumes an APB master on the core clock and stream logic that
 * writes and reads the buffers on the same clock.
 */
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`include "slip_evt_defs.svh"

// Summary of operation
// - Empty receive read repeats frame, sets bit 1
// - Status bits sticky, cleared by read, reset 0
// - Receive slip bit 0 on fill or empty
// - Full receive write deletes frame, sets slip
// - Enable bit 7 read-write, resets to 0
// - Full transmit write deletes frame, sets status
// - Enable bit 7 gates transmit full interrupt
// - Full receive write sets bit 2
module slip_event_ctrl
    import slip_evt_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [`APB_AW-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Interrupt
    output logic o_irq,
    // Receive slip buffer: line side writes, backplane reads
    input wire logic i_rx_wr_valid,
    input wire logic [7:0] i_rx_wr_data,
    input wire logic i_rx_rd_req,
    output logic [7:0] o_rx_rd_data,
    output logic o_rx_rd_valid,
    // Transmit slip buffer: backplane writes, line side reads
    input wire logic i_tx_wr_valid,
    input wire logic [7:0] i_tx_wr_data,
    input wire logic i_tx_rd_req,
    output logic [7:0] o_tx_rd_data,
    output logic o_tx_rd_valid
);
    // ==========================================================
    // Address decode
    function automatic logic reg_hit(input logic [`APB_AW-1:0] a,
                                     input logic [11:0] idx);
        reg_hit = (a[1:0] == 2'h0) && (a[`APB_AW-1:14] == 2'h0) && (a[13:2] == idx);
    endfunction

    apb_state_e state;
    apb_state_e next_state;
    byte_t enable;
    logic [5:0] flags;

    wire hit_st = reg_hit(i_paddr, `IDX_STATUS);
    wire hit_en = reg_hit(i_paddr, `IDX_ENABLE);
    wire hit_tx = reg_hit(i_paddr, `IDX_TX_STATUS);
    wire mapped = hit_st | hit_en | hit_tx;
    wire setup = i_psel & ~i_penable & (state == ST_IDLE);
    wire done = i_psel & i_penable & o_pready;
    wire wr_ok = done & i_pwrite & ~o_pslverr & i_pstrb[0];
    wire rd_ok = done & ~i_pwrite & ~o_pslverr;

    // ==========================================================
    // Buffers
    slip_event_if rx_ev ();
    slip_event_if tx_ev ();

    slip_buffer u_rx_buf (
        .i_core_clk (i_core_clk),
        .i_rstn (i_rstn),
        .i_wr (i_rx_wr_valid),
        .i_wr_data (i_rx_wr_data),
        .i_rd (i_rx_rd_req),
        .o_rd_data (o_rx_rd_data),
        .o_rd_valid (o_rx_rd_valid),
        .ev (rx_ev.src)
    );

    slip_buffer u_tx_buf (
        .i_core_clk (i_core_clk),
        .i_rstn (i_rstn),
        .i_wr (i_tx_wr_valid),
        .i_wr_data (i_tx_wr_data),
        .i_rd (i_tx_rd_req),
        .o_rd_data (o_tx_rd_data),
        .o_rd_valid (o_tx_rd_valid),
        .ev (tx_ev.src)
    );

    // ==========================================================
    // Status flags: [2:0] receive, [5:3] transmit
    wire [2:0] rx_set;
    wire [2:0] tx_set;
    assign rx_set[`BIT_RX_SLIP] = rx_ev.full_slip | rx_ev.empty_slip;
    assign rx_set[`BIT_RX_EMPTY] = rx_ev.empty_slip;
    assign rx_set[`BIT_RX_FULL] = rx_ev.full_slip;
    assign tx_set[`BIT_TX_SLIP-5] = tx_ev.full_slip | tx_ev.empty_slip;
    assign tx_set[`BIT_TX_EMPTY-5] = tx_ev.empty_slip;
    assign tx_set[`BIT_TX_FULL-5] = tx_ev.full_slip;

    // Read clears only what was returned, so an event landing between
    // the setup and access edges is not lost
    wire [2:0] rx_rd_clr = (rd_ok & hit_st) ? o_prdata[2:0] : 3'h0;
    wire [2:0] tx_rd_clr = (rd_ok & hit_tx) ? o_prdata[7:5] : 3'h0;
    wire [2:0] rx_wr_clr = (wr_ok & hit_st) ? i_pwdata[2:0] : 3'h0;
    wire [2:0] tx_wr_clr = (wr_ok & hit_tx) ? i_pwdata[7:5] : 3'h0;

    event_latch #(
        .W (6)
    ) u_flags (
        .i_core_clk (i_core_clk),
        .i_rstn (i_rstn),
        .i_set ({tx_set, rx_set}),
        .i_clr ({tx_rd_clr | tx_wr_clr, rx_rd_clr | rx_wr_clr}),
        .o_flags (flags)
    );

    // ==========================================================
    // Read mux; reserved bits read as zero
    wire [31:0] rd_word = hit_st ? {29'h0, flags[2:0]} :
                          hit_en ? {24'h0, enable} :
                          hit_tx ? {24'h0, flags[5:3], 5'h00} : 32'h0;
    wire [2:0] rx_unmasked = flags[2:0] & enable[2:0];
    wire [2:0] tx_unmasked = flags[5:3] & enable[7:5];
    wire irq_any = |{rx_unmasked, tx_unmasked};
    assign next_state = setup ? ST_ACCESS : (done ? ST_IDLE : state);

    // ==========================================================
    // APB slave: one wait-free access phase after each setup
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= ST_IDLE;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h0;
        end else begin
            state <= next_state;
            o_pready <= setup;
            o_pslverr <= setup ? ~mapped : (done ? 1'b0 : o_pslverr);
            o_prdata <= setup ? (i_pwrite ? 32'h0 : rd_word) : o_prdata;
        end
    end

    // ==========================================================
    // Enable register and interrupt
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            enable <= `RST_ENABLE;
            o_irq <= 1'b0;
        end else begin
            if (wr_ok && hit_en) begin
                enable <= i_pwdata[7:0] & `ENABLE_MASK;
            end
            o_irq <= irq_any;
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);

    AST_RX_EMPTY_SETS: assert property (
        rx_ev.empty_slip |=> flags[`BIT_RX_EMPTY] && flags[`BIT_RX_SLIP])
        else $error("receive empty slip not latched");

    AST_RX_READ_CLEARS: assert property (
        (rd_ok && hit_st && rx_set == 3'h0)
        |=> ((flags[2:0] & $past(o_prdata[2:0])) == 3'h0))
        else $error("status read did not clear returned bits");

    AST_SET_BEATS_CLEAR: assert property (
        (rd_ok && hit_st && rx_ev.full_slip) |=> flags[`BIT_RX_FULL])
        else $error("event lost in clearing cycle");

    AST_FLAG_HOLDS: assert property (
        (flags[`BIT_RX_FULL] && !(done && (hit_st || hit_tx)))
        |=> flags[`BIT_RX_FULL])
        else $error("status bit dropped without a read or write");

    AST_SLIP_ON_EITHER: assert property (
        (rx_ev.full_slip || rx_ev.empty_slip) |=> flags[`BIT_RX_SLIP])
        else $error("receive slip bit not set");

    AST_SLIP_HAS_CAUSE: assert property (
        $rose(flags[`BIT_RX_SLIP]) |-> $past(rx_ev.full_slip || rx_ev.empty_slip))
        else $error("receive slip bit set without a slip");

    AST_RX_FULL_SETS: assert property (
        rx_ev.full_slip |=> flags[`BIT_RX_FULL] && flags[`BIT_RX_SLIP])
        else $error("receive full slip not latched");

    AST_EN7_WRITE: assert property (
        (wr_ok && hit_en) |=> (enable[`BIT_TX_FULL] == $past(i_pwdata[`BIT_TX_FULL])))
        else $error("enable bit 7 did not take written value");

    AST_EN7_READBACK: assert property (
        (setup && hit_en && !i_pwrite) |=> (o_prdata[`BIT_TX_FULL] == enable[`BIT_TX_FULL]))
        else $error("enable bit 7 read back wrong");

    AST_TX_FULL_SETS: assert property (
        tx_ev.full_slip |=> flags[3 + `BIT_TX_FULL - 5])
        else $error("transmit full slip not latched");

    AST_TX_IRQ_ON: assert property (
        (flags[5] && enable[`BIT_TX_FULL]) |=> o_irq)
        else $error("enabled transmit full did not interrupt");

    AST_IRQ_OFF_MASKED: assert property (
        (enable == 8'h00) [*2] |-> !o_irq)
        else $error("interrupt raised with all enables clear");

    AST_RX_FULL_BIT2: assert property (
        $rose(flags[`BIT_RX_FULL]) |-> $past(rx_ev.full_slip))
        else $error("receive full bit set without a full slip");

    AST_IRQ_CAUSE: assert property (
        o_irq |-> $past(|(flags[2:0] & enable[2:0]) || |(flags[5:3] & enable[7:5])))
        else $error("interrupt without an enabled status bit");

    AST_APB_ONE_WAIT: assert property (
        setup |=> o_pready ##1 !o_pready)
        else $error("ready not a single access cycle");

    AST_UNMAPPED_ERR: assert property (
        (setup && !mapped) |=> o_pslverr && o_pready)
        else $error("unmapped access not answered with error");

    AST_RX_EMPTY_CAUSE: assert property (
        $rose(flags[`BIT_RX_EMPTY]) |-> $past(rx_ev.empty_slip))
        else $error("receive empty bit set without an empty slip");

    AST_RX_EMPTY_HOLDS: assert property (
        (flags[`BIT_RX_EMPTY] && !(done && hit_st)) |=> flags[`BIT_RX_EMPTY])
        else $error("receive empty bit dropped without access");

    AST_RX_SLIP_HOLDS: assert property (
        (flags[`BIT_RX_SLIP] && !(done && hit_st)) |=> flags[`BIT_RX_SLIP])
        else $error("receive slip bit dropped without access");

    AST_EMPTY_BEATS_CLEAR: assert property (
        (rd_ok && hit_st && rx_ev.empty_slip) |=> flags[`BIT_RX_EMPTY] && flags[`BIT_RX_SLIP])
        else $error("empty slip lost in clearing cycle");

    AST_ST_READ_DATA: assert property (
        (setup && hit_st && !i_pwrite) |=> (o_prdata == {29'h0, $past(flags[2:0])}))
        else $error("receive status read back wrong");

    AST_WRITE_ONE_CLEARS: assert property (
        (wr_ok && hit_st && rx_set == 3'h0) |=> ((flags[2:0] & $past(i_pwdata[2:0])) == 3'h0))
        else $error("write of one did not clear status");

    AST_TX_EMPTY_SETS: assert property (
        tx_ev.empty_slip |=> flags[4] && flags[3])
        else $error("transmit empty slip not latched");

    AST_TX_SLIP_ON_FULL: assert property (
        tx_ev.full_slip |=> flags[3])
        else $error("transmit slip bit not set on full slip");

    AST_TX_FULL_CAUSE: assert property (
        $rose(flags[5]) |-> $past(tx_ev.full_slip))
        else $error("transmit full bit set without a full slip");

    AST_TX_FULL_HOLDS: assert property (
        (flags[5] && !(done && hit_tx)) |=> flags[5])
        else $error("transmit full bit dropped without access");

    AST_TX_FULL_BEATS_CLEAR: assert property (
        (rd_ok && hit_tx && tx_ev.full_slip) |=> flags[5])
        else $error("transmit full slip lost in clearing cycle");

    AST_TX_READ_CLEARS: assert property (
        (rd_ok && hit_tx && tx_set == 3'h0) |=> ((flags[5:3] & $past(o_prdata[7:5])) == 3'h0))
        else $error("transmit status read did not clear");

    AST_TX_READ_DATA: assert property (
        (setup && hit_tx && !i_pwrite) |=> (o_prdata == {24'h0, $past(flags[5:3]), 5'h00}))
        else $error("transmit status read back wrong");

    AST_TX_SLIP_CAUSE: assert property (
        $rose(flags[3]) |-> $past(tx_ev.full_slip || tx_ev.empty_slip))
        else $error("transmit slip bit set without a slip");

    AST_EN_READ_DATA: assert property (
        (setup && hit_en && !i_pwrite) |=> (o_prdata == {24'h0, $past(enable)}))
        else $error("enable register read back wrong");

    AST_EN_HOLDS: assert property (
        !(wr_ok && hit_en) |=> $stable(enable))
        else $error("enable changed without a write");

    AST_EN_RESERVED: assert property (
        (enable & ~`ENABLE_MASK) == 8'h00)
        else $error("reserved enable bits set");

    AST_STRB_IGNORED: assert property (
        (done && i_pwrite && !i_pstrb[0]) |=> $stable(enable))
        else $error("write without strobe took effect");

    AST_RX_IRQ_ON: assert property (
        (|(flags[2:0] & enable[2:0])) |=> o_irq)
        else $error("enabled receive status did not interrupt");

    AST_IRQ_OFF: assert property (
        ((flags[2:0] & enable[2:0]) == 3'h0 && (flags[5:3] & enable[7:5]) == 3'h0) |=> !o_irq)
        else $error("interrupt without enabled status");

    AST_TX_MASKED: assert property (
        (!enable[`BIT_TX_FULL] && enable[6:0] == 7'h00) |=> !o_irq)
        else $error("masked transmit full interrupted");

    AST_ERR_WITH_READY: assert property (
        o_pslverr |-> o_pready)
        else $error("error outside the access cycle");

    AST_ERR_READS_ZERO: assert property (
        (setup && !mapped && !i_pwrite) |=> (o_prdata == 32'h0))
        else $error("unmapped read returned data");

    AST_ERR_NO_WRITE: assert property (
        (done && o_pslverr) |=> $stable(enable))
        else $error("refused write changed enable");

    AST_READY_NEEDS_SEL: assert property (
        !i_psel |=> !o_pready)
        else $error("ready without a selected transfer");

    AST_SETUP_TO_ACCESS: assert property (
        setup |=> (state == ST_ACCESS))
        else $error("setup did not enter access");

    AST_DONE_TO_IDLE: assert property (
        done |=> (state == ST_IDLE))
        else $error("completed access did not return to idle");
endmodule

// ==== tb/stream_agent.sv ====
/*
 * Far-side stream logic of one slip buffer: writes and reads bytes
 * and predicts every byte that comes back, slips included.
 * Assumes the buffer is empty when the first task is called and that
 * a write and a read are never asked for in the same cycle.
 */
`timescale 1ns/1ps
module stream_agent
    import slip_evt_pkg::*;
(
    // Clock
    input wire logic i_core_clk,
    // Stream
    output logic o_wr_valid,
    output byte_t o_wr_data,
    output logic o_rd_req
);
    // ==========================================================
    // Image of the two-frame buffer
    byte_t mem [64];
    byte_t exp_q [$];
    int wp = 0;
    int rp = 0;
    int cnt = 0;

    initial begin
        o_wr_valid = 1'b0;
        o_wr_data = 8'h00;
        o_rd_req = 1'b0;
    end

    // ==========================================================
    // Stream tasks
    task automatic put(input int n);
        byte_t b;
        for (int k = 0; k <= n; k++) begin
            @(posedge i_core_clk);
            b = 8'($urandom);
            if (k < n) begin
                if (cnt == 64) begin
                    rp = (rp + 32) % 64;
                    cnt = 32;
                end
                mem[wp] = b;
                wp = (wp + 1) % 64;
                cnt++;
            end
            o_wr_valid <= (k < n);
            // Idle data is random too, so a late sample of it shows up
            o_wr_data <= b;
        end
    endtask

    task automatic get(input int n);
        for (int k = 0; k <= n; k++) begin
            @(posedge i_core_clk);
            if (k < n) begin
                if (cnt == 0) begin
                    rp = (rp + 32) % 64;
                    cnt = 32;
                end
                exp_q.push_back(mem[rp]);
                rp = (rp + 1) % 64;
                cnt--;
            end
            o_rd_req <= (k < n);
        end
    endtask
endmodule

// ==== tb/testbench.sv ====
/*
 * Self-checking bench of the slip event block: APB register traffic,
 * slips in both buffers and the interrupt output.
 * Assumes the package, the defines header and stream_agent are compiled.
 */
`timescale 1ns/1ps
`include "slip_evt_defs.svh"
module testbench
    import slip_evt_pkg::*;
;
    // ==========================================================
    // Addresses and event patterns
    localparam logic [15:0] A_ST = `IDX_STATUS * 4;
    localparam logic [15:0] A_EN = `IDX_ENABLE * 4;
    localparam logic [15:0] A_TX = `IDX_TX_STATUS * 4;
    localparam byte_t RX_EMPTY_EV = (8'h1 << `BIT_RX_SLIP) | (8'h1 << `BIT_RX_EMPTY);
    localparam byte_t RX_FULL_EV = (8'h1 << `BIT_RX_SLIP) | (8'h1 << `BIT_RX_FULL);
    localparam byte_t TX_FULL_EV = (8'h1 << `BIT_TX_SLIP) | (8'h1 << `BIT_TX_FULL);
    localparam byte_t TX_EMPTY_EV = (8'h1 << `BIT_TX_SLIP) | (8'h1 << `BIT_TX_EMPTY);

    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_psel, i_penable, i_pwrite;
    logic [15:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata;
    logic [3:0] i_pstrb;
    logic o_pready, o_pslverr, o_irq;
    logic i_rx_wr_valid, i_rx_rd_req, o_rx_rd_valid;
    logic i_tx_wr_valid, i_tx_rd_req, o_tx_rd_valid;
    byte_t i_rx_wr_data, o_rx_rd_data, i_tx_wr_data, o_tx_rd_data;
    int num_errors = 0;
    int checks_done = 0;
    logic [32:0] apb_q [$];
    byte_t r;

    always #4 i_core_clk = ~i_core_clk;

    slip_event_ctrl i_slip_event_ctrl (.i_core_clk, .i_rstn, .i_psel, .i_penable,
        .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr,
        .o_irq, .i_rx_wr_valid, .i_rx_wr_data, .i_rx_rd_req, .o_rx_rd_data,
        .o_rx_rd_valid, .i_tx_wr_valid, .i_tx_wr_data, .i_tx_rd_req, .o_tx_rd_data,
        .o_tx_rd_valid);
    stream_agent rx_agent (.i_core_clk, .o_wr_valid(i_rx_wr_valid),
        .o_wr_data(i_rx_wr_data), .o_rd_req(i_rx_rd_req));
    stream_agent tx_agent (.i_core_clk, .o_wr_valid(i_tx_wr_valid),
        .o_wr_data(i_tx_wr_data), .o_rd_req(i_tx_rd_req));

    // ==========================================================
    // Comparison, verdict and bus tasks
    task automatic check(input logic [32:0] seen, input logic [32:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // The expectation is noted at setup; the monitor takes it at completion
    task automatic apb(input logic wr, input logic [15:0] a, input byte_t d,
                       input logic [32:0] exp);
        @(posedge i_core_clk);
        i_psel <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite <= wr;
        i_paddr <= a;
        i_pwdata <= {24'h0, d};
        apb_q.push_back(exp);
        @(posedge i_core_clk);
        i_penable <= 1'b1;
        // Only the watchdog ends a wait for ready
        do begin
            @(posedge i_core_clk);
        end while (o_pready !== 1'b1);
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input byte_t e);
        apb(1'b0, a, 8'h00, {25'h0, e});
    endtask

    task automatic wr(input logic [15:0] a, input byte_t d);
        apb(1'b1, a, d, 33'h0);
    endtask

    // Status lands one cycle after the slip, the interrupt one cycle later
    task automatic irq_is(input logic e);
        repeat (4) @(posedge i_core_clk);
        check({32'h0, o_irq}, {32'h0, e}, "irq");
    endtask

    // ==========================================================
    // Monitor
    always @(posedge i_core_clk) begin
        if (i_psel && i_penable && o_pready === 1'b1) begin
            check({o_pslverr, i_pwrite ? 32'h0 : o_prdata}, apb_q.pop_front(), "apb");
        end
        if (o_rx_rd_valid === 1'b1) begin
            check({25'h0, o_rx_rd_data}, {25'h0, rx_agent.exp_q.pop_front()}, "rx");
        end
        if (o_tx_rd_valid === 1'b1) begin
            check({25'h0, o_tx_rd_data}, {25'h0, tx_agent.exp_q.pop_front()}, "tx");
        end
    end

    initial begin
        #160000;
        num_errors++;
        $display("BAD t=%0t watchdog", $time);
        print_verdict();
    end

    // ==========================================================
    // Tests
    initial begin
        void'($urandom(32'h19b263c5));
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 16'h0000;
        i_pwdata = 32'h0;
        // Only the lowest strobe matters; the others are random
        i_pstrb = {3'($urandom), 1'b1};
        repeat (12) @(posedge i_core_clk);
        i_rstn <= 1'b1;
        rd(A_ST, 8'h00);
        rd(A_EN, 8'h00);
        rd(A_TX, 8'h00);
        irq_is(1'b0);
        $display("test reset done");
        r = 8'($urandom);
        wr(A_EN, 8'hff);
        rd(A_EN, `ENABLE_MASK);
        i_pstrb <= {3'($urandom), 1'b0};
        wr(A_EN, 8'h00);
        i_pstrb <= {3'($urandom), 1'b1};
        rd(A_EN, `ENABLE_MASK);
        wr(A_EN, r);
        rd(A_EN, r & `ENABLE_MASK);
        apb(1'b0, A_TX + 16'h4, 8'h00, {1'b1, 32'h0});
        apb(1'b0, A_ST + 16'h1, 8'h00, {1'b1, 32'h0});
        $display("test registers done");
        wr(A_EN, 8'h01);
        rx_agent.put(32);
        rx_agent.get(32);
        rd(A_ST, 8'h00);
        rx_agent.get(1);
        irq_is(1'b1);
        rd(A_ST, RX_EMPTY_EV);
        rd(A_ST, 8'h00);
        irq_is(1'b0);
        rx_agent.get(31);
        $display("test receive empty done");
        wr(A_EN, 8'h02);
        rx_agent.put(65);
        irq_is(1'b0);
        wr(A_EN, 8'h04);
        irq_is(1'b1);
        rd(A_ST, RX_FULL_EV);
        irq_is(1'b0);
        rx_agent.get(33);
        rd(A_ST, 8'h00);
        $display("test receive full done");
        wr(A_EN, 8'h00);
        tx_agent.put(65);
        irq_is(1'b0);
        wr(A_EN, 8'h80);
        irq_is(1'b1);
        rd(A_TX, TX_FULL_EV);
        irq_is(1'b0);
        tx_agent.get(34);
        rd(A_TX, TX_EMPTY_EV);
        $display("test transmit done");
        repeat (4) @(posedge i_core_clk);
        check(33'(rx_agent.exp_q.size()), 33'h0, "rx left");
        check(33'(tx_agent.exp_q.size()), 33'h0, "tx left");
        check(33'(apb_q.size()), 33'h0, "apb left");
        print_verdict();
    end
endmodule
